// ---- core/urx_receiver.sv ----
// serial receiver with start detection, majority vote and two-entry buffer
//
// Contract
// - receive-complete is high exactly while the buffer holds unread data.
// - clearing receiver enable flushes the buffer; receive-complete drops.
// - interrupt request is flag and enable and global enable, held as level.
// - each data read of a non-empty buffer advances the buffer read position.
// - frame, overrun and parity flags stored with each character.
// - error flags are read-only; status writes cannot alter them.
// - error flags never raise an interrupt request.
// - frame error is one when first stop bit sampled zero.
// - buffer holds two; overrun on full buffer, waiting shift, new start.
// - overrun shows lost frames; clears on successful transfer into buffer.
// - parity error reads zero when parity checking disabled.
// - checker active when upper parity bit set; lower selects type.
// - parity compared at reception, stored, valid until character read.
// - disabling is immediate, abandons reception, releases the pin.
// - oversample sixteen per bit normally, eight in double speed.
// - start detection on falling edge; first low sample is sample 1.
// - start vote on samples 8,9,10 normal or 4,5,6 double speed.
// - two or more high voting samples reject start as noise.
// - bit timing realigns to every valid start bit.
// - shift bits until first stop bit; second stop ignored; then transfer.
// - unused upper data bits read zero for short characters.
// - ninth bit kept in the buffer entry, read with status.
// - each bit decided by majority of its three centre samples; data and stop bits use samples 9,10,11 (5,6,7 double speed).
`timescale 1ns/1ns
module urx_receiver #(
    parameter int DEPTH = urx_pkg::FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic sample_tick_i,
    input wire logic rx_pin_i,
    input wire urx_pkg::urx_cfg_t cfg_i,
    input wire logic data_read_i,
    output logic rx_pin_claim_o,
    output logic receive_complete_o,
    output logic irq_o,
    output logic frame_error_flag_o,
    output logic overrun_flag_o,
    output logic parity_error_flag_o,
    output logic ninth_rx_bit_o,
    output logic [7:0] rx_data_o
);
    function automatic logic vote3(input logic [2:0] s);
        vote3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    // size codes 0..3 give five to eight bits, code 7 gives nine
    function automatic logic [3:0] data_bits(input logic [2:0] sz);
        if (sz == urx_pkg::CSIZE_9BIT) begin
            data_bits = 4'h9;
        end else begin
            data_bits = {1'b0, sz} + 4'h5;
        end
    endfunction

    // the third centre sample closes each vote
    function automatic logic centre_end(input logic [4:0] samp,
                                        input logic [4:0] first);
        centre_end = samp == first + 5'h02;
    endfunction

    urx_pkg::urx_entry_t fifo_r [DEPTH];
    logic [1:0] rd_ptr_r;
    logic [1:0] wr_ptr_r;
    logic [1:0] count_r;
    urx_pkg::urx_state_t state_r;
    logic [4:0] samp_r;
    logic [2:0] vote_r;
    logic [3:0] bitn_r;
    // received bits enter at the top and move down
    logic [8:0] shift_r;
    logic par_bit_r;
    logic prev_rx_r;
    logic hold_valid_r;
    urx_pkg::urx_entry_t hold_r;
    // a frame was dropped since the last transfer
    logic lost_r;

    logic en;
    logic [4:0] ovs;
    logic [4:0] vfirst;
    logic [3:0] nbits;
    logic has_par;
    logic [3:0] last_idx;
    logic pop;
    logic push;
    logic bit_val;
    logic bit_done;
    logic start_seen;
    logic vote_pt;
    logic frame_end;
    logic full_w;
    urx_pkg::urx_entry_t done_entry;
    logic [8:0] masked;
    logic perr;

    assign en = cfg_i.receiver_enable_bit;
    // samples per bit; double speed halves them and the tolerance
    assign ovs = cfg_i.double_speed_bit ? urx_pkg::OVS_DOUBLE
                                        : urx_pkg::OVS_NORMAL;
    assign vfirst = cfg_i.double_speed_bit ? urx_pkg::VOTE_FIRST_DOUBLE
                                           : urx_pkg::VOTE_FIRST_NORMAL;
    // stop_bit_count_select is not read: only the first stop is checked
    assign nbits = data_bits(cfg_i.character_size_field);
    // the parity bit is present only when checking is on
    assign has_par = cfg_i.parity_mode_upper_bit;
    // index of the first stop bit; data bits count from 0
    assign last_idx = nbits + {3'h0, has_par};
    // reads on an empty buffer are ignored
    assign pop = data_read_i && count_r != 2'h0;
    assign full_w = count_r == DEPTH[1:0];
    // holding register waits while both entries are unread
    assign push = hold_valid_r && !full_w;
    // majority of the two stored samples and the current one
    assign bit_val = vote3({vote_r[1:0], rx_pin_i});
    assign bit_done = state_r == urx_pkg::URX_BITS && sample_tick_i
                      && samp_r == ovs;
    // falling edge seen on an idle line
    assign start_seen = state_r == urx_pkg::URX_IDLE && sample_tick_i
                        && prev_rx_r && !rx_pin_i;
    assign vote_pt = state_r == urx_pkg::URX_BITS && sample_tick_i
                     && centre_end(samp_r, vfirst);
    // first stop bit voted: frame leaves the shift register
    assign frame_end = vote_pt && bitn_r == last_idx;

    // entry built at the stop vote from the shift register
    always_comb begin
        masked = shift_r >> (4'h9 - nbits);
        perr = ^masked ^ par_bit_r ^ cfg_i.parity_mode_lower_bit;
        done_entry.data = masked;
        done_entry.frame_error_flag = !bit_val;
        done_entry.overrun_flag = lost_r;
        done_entry.parity_error_flag = has_par && perr;
    end

    // start detection and bit sequencing
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || !en) begin
            state_r <= urx_pkg::URX_IDLE;
            samp_r <= 5'h00;
            bitn_r <= 4'h0;
            prev_rx_r <= 1'b1;
        end else if (sample_tick_i) begin
            prev_rx_r <= rx_pin_i;
            case (state_r)
                urx_pkg::URX_IDLE: begin
                    if (start_seen) begin
                        state_r <= urx_pkg::URX_START;
                        samp_r <= 5'h01;
                    end
                end
                urx_pkg::URX_START: begin
                    samp_r <= samp_r + 5'h01;
                    if (centre_end(samp_r + 5'h01, vfirst)) begin
                        if (vote3({vote_r[1:0], rx_pin_i})) begin
                            state_r <= urx_pkg::URX_IDLE;
                            // the line must rise again before a new try
                            prev_rx_r <= 1'b0;
                        end
                    end else if (samp_r == ovs) begin
                        // realign: this tick took bit 0's sample 1; the count restarts at 1 next tick
                        state_r <= urx_pkg::URX_BITS;
                        samp_r <= 5'h01;
                        bitn_r <= 4'h0;
                    end
                end
                urx_pkg::URX_BITS: begin
                    if (bit_done) begin
                        samp_r <= 5'h01;
                        bitn_r <= bitn_r + 4'h1;
                    end else begin
                        samp_r <= samp_r + 5'h01;
                    end
                    if (frame_end) begin
                        // first stop decided; a second stop is ignored
                        state_r <= urx_pkg::URX_IDLE;
                        // a low stop is no edge: the next start needs a fall
                    end
                end
                default: state_r <= urx_pkg::URX_IDLE;
            endcase
        end
    end

    // sample history for the three-sample votes
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || !en) begin
            vote_r <= 3'h0;
        end else if (sample_tick_i) begin
            vote_r <= {vote_r[1:0], rx_pin_i};
        end
    end

    // data shift; vote at the last centre sample
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            shift_r <= 9'h000;
            par_bit_r <= 1'b0;
        end else if (vote_pt) begin
            if (bitn_r < nbits) begin
                shift_r <= {bit_val, shift_r[8:1]};
            end else if (bitn_r == nbits) begin
                par_bit_r <= bit_val;
            end
        end
    end

    // completed frame waits here while the buffer is full
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || !en) begin
            hold_valid_r <= 1'b0;
            hold_r <= '0;
            lost_r <= 1'b0;
        end else begin
            if (frame_end) begin
                // a full holding register drops the frame; the loss
                // is carried by the next frame that gets through
                if (!hold_valid_r || push) begin
                    hold_valid_r <= 1'b1;
                    hold_r <= done_entry;
                    lost_r <= 1'b0;
                end
            end else if (push) begin
                hold_valid_r <= 1'b0;
            end
            if (start_seen && hold_valid_r && full_w) begin
                lost_r <= 1'b1;
            end
        end
    end

    // storage has no reset: only entries below the count are ever shown
    always_ff @(posedge clk_i) begin
        if (push) begin
            fifo_r[wr_ptr_r[0]] <= hold_r;
        end
    end

    // two-entry buffer; flushed at once on disable
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || !en) begin
            rd_ptr_r <= 2'h0;
            wr_ptr_r <= 2'h0;
            count_r <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 2'h1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 2'h1;
            end
            // a read and a write in one cycle leave the count as it is
            count_r <= count_r + {1'b0, push} - {1'b0, pop};
        end
    end

    // registered outputs; error flags have no write path at all
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rx_pin_claim_o <= 1'b0;
            receive_complete_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            // pin is handed back at once when the receiver is off
            rx_pin_claim_o <= en;
            receive_complete_o <= en && count_r != 2'h0;
            // error flags are not part of the request
            irq_o <= en && count_r != 2'h0
                     && cfg_i.receive_complete_irq_enable
                     && cfg_i.global_irq_enable;
        end
    end

    // head of the buffer as seen by status and data reads
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            frame_error_flag_o <= 1'b0;
            overrun_flag_o <= 1'b0;
            parity_error_flag_o <= 1'b0;
            ninth_rx_bit_o <= 1'b0;
            rx_data_o <= 8'h00;
        end else begin
            if (en && count_r != 2'h0) begin
                frame_error_flag_o <= fifo_r[rd_ptr_r[0]].frame_error_flag;
                overrun_flag_o <= fifo_r[rd_ptr_r[0]].overrun_flag;
                parity_error_flag_o <= fifo_r[rd_ptr_r[0]].parity_error_flag;
                ninth_rx_bit_o <= fifo_r[rd_ptr_r[0]].data[8];
                rx_data_o <= fifo_r[rd_ptr_r[0]].data[7:0];
            end else begin
                frame_error_flag_o <= 1'b0;
                overrun_flag_o <= 1'b0;
                parity_error_flag_o <= 1'b0;
                ninth_rx_bit_o <= 1'b0;
                rx_data_o <= 8'h00;
            end
        end
    end
endmodule

// ---- pkg/urx_pkg.sv ----
// package for the serial receiver: constants, modes and carrier types
package urx_pkg;
    localparam int FIFO_DEPTH = 2;
    localparam logic [4:0] OVS_NORMAL = 5'h10;
    localparam logic [4:0] OVS_DOUBLE = 5'h08;
    localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
    localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
    localparam logic [2:0] CSIZE_9BIT = 3'h7;
    localparam logic [1:0] PAR_EVEN = 2'h2;
    localparam logic [1:0] PAR_ODD = 2'h3;

    typedef struct packed {
        logic [8:0] data;
        logic frame_error_flag;
        logic overrun_flag;
        logic parity_error_flag;
    } urx_entry_t;

    typedef struct packed {
        logic receiver_enable_bit;
        logic receive_complete_irq_enable;
        logic global_irq_enable;
        logic double_speed_bit;
        logic parity_mode_upper_bit;
        logic parity_mode_lower_bit;
        logic stop_bit_count_select;
        logic [2:0] character_size_field;
    } urx_cfg_t;

    typedef enum logic [1:0] {
        URX_IDLE,
        URX_START,
        URX_BITS
    } urx_state_t;
endpackage

// ---- tb/urx_line_model.sv ----
// serial transmitter model driving the receive line
`timescale 1ns/1ns
module urx_line_model (
    input wire logic clk_i,
    input wire logic tick_i,
    output logic line_o
);
    initial line_o = 1'b1;
    task automatic ticks(input int k);
        repeat (k) begin
            @(posedge clk_i);
            while (tick_i !== 1'b1) @(posedge clk_i);
        end
        @(negedge clk_i);
    endtask
    task automatic send(input logic [10:0] v, input int n, input int s);
        line_o = 1'b0;
        ticks(s);
        for (int i = 0; i < n; i++) begin
            line_o = v[i];
            ticks(s);
        end
        line_o = 1'b1;
        ticks(2 * s);
    endtask
    task automatic glitch(input int k);
        line_o = 1'b0;
        ticks(k);
        line_o = 1'b1;
        ticks(200);
    endtask
endmodule

// ---- tb/urx_receiver_checker.sv ----
// concurrent checks on the receiver ports
`timescale 1ns/1ns
module urx_receiver_checker #(
    parameter int DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic sample_tick_i,
    input wire logic rx_pin_i,
    input wire urx_pkg::urx_cfg_t cfg_i,
    input wire logic data_read_i,
    input wire logic rx_pin_claim_o,
    input wire logic receive_complete_o,
    input wire logic irq_o,
    input wire logic frame_error_flag_o,
    input wire logic overrun_flag_o,
    input wire logic parity_error_flag_o,
    input wire logic ninth_rx_bit_o,
    input wire logic [7:0] rx_data_o
);
    wire logic en = cfg_i.receiver_enable_bit;
    wire logic ien = cfg_i.receive_complete_irq_enable
        && cfg_i.global_irq_enable;
    wire logic quiet = !data_read_i && en;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    a_claim_on: assert property ($past(rst_b_i) && $past(en)
        |-> rx_pin_claim_o) else $error("pin not claimed");
    a_claim_off: assert property (!$past(en) |-> !rx_pin_claim_o)
        else $error("pin claimed while disabled");
    a_disable_flush: assert property ((!en) [*3]
        |-> !receive_complete_o) else $error("flush missing");
    a_rc_needs_en: assert property (receive_complete_o |-> $past(en))
        else $error("complete while disabled");
    a_irq_gated: assert property ((receive_complete_o && ien) [*2]
        |-> irq_o) else $error("irq missing");
    a_irq_needs_en: assert property (irq_o |-> $past(ien))
        else $error("irq without enable");
    a_flags_empty: assert property (!receive_complete_o ##1
        !receive_complete_o |-> !irq_o && !(frame_error_flag_o
        || overrun_flag_o || parity_error_flag_o))
        else $error("flag or irq while empty");
    a_head_holds: assert property (receive_complete_o
        && $past(receive_complete_o) && quiet && $past(quiet)
        && $past(quiet, 2) |=> receive_complete_o && $stable({rx_data_o,
        ninth_rx_bit_o, frame_error_flag_o, parity_error_flag_o}))
        else $error("head changed without read");
endmodule
bind urx_receiver urx_receiver_checker #(.DEPTH(DEPTH)) chk (.clk_i,
    .rst_b_i, .sample_tick_i, .rx_pin_i, .cfg_i, .data_read_i,
    .rx_pin_claim_o, .receive_complete_o, .irq_o, .frame_error_flag_o,
    .overrun_flag_o, .parity_error_flag_o, .ninth_rx_bit_o, .rx_data_o);

// ---- tb/urx_receiver_tb.sv ----
// self-checking testbench for the serial receiver
`timescale 1ns/1ns
module urx_receiver_tb;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic tick = 1'b0;
    logic rd = 1'b0;
    logic line, claim, rc, irq, fe, ov, pe, b8;
    logic [7:0] dat;
    urx_pkg::urx_cfg_t cfg = '0;
    int bad_count = 0;
    int n_compared = 0;
    always #4 clk_i = ~clk_i;
    always @(negedge clk_i) tick <= ~tick;
    urx_line_model tx (.clk_i(clk_i), .tick_i(tick), .line_o(line));
    urx_receiver uut (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .sample_tick_i(tick), .rx_pin_i(line), .cfg_i(cfg),
        .data_read_i(rd), .rx_pin_claim_o(claim),
        .receive_complete_o(rc), .irq_o(irq), .frame_error_flag_o(fe),
        .overrun_flag_o(ov), .parity_error_flag_o(pe),
        .ninth_rx_bit_o(b8), .rx_data_o(dat));
    function automatic logic [11:0] head();
        return {b8, dat, fe, ov, pe};
    endfunction
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic frame(input logic [8:0] d, input int n,
        input logic p, input logic st);
        logic [10:0] v;
        int k;
        v = 11'(d);
        k = n;
        if (cfg.parity_mode_upper_bit) begin
            v[k] = p;
            k++;
        end
        v[k] = st;
        tx.send(v, k + 1, cfg.double_speed_bit ? 8 : 16);
    endtask
    task automatic wait_rc();
        int i;
        i = 0;
        while (rc !== 1'b1 && i < 2000) begin
            @(negedge clk_i);
            i++;
        end
        if (rc !== 1'b1) begin
            bad_count++;
            test_done();
        end
    endtask
    task automatic pop();
        rd = 1'b1;
        @(negedge clk_i);
        rd = 1'b0;
        repeat (3) @(negedge clk_i);
    endtask
    task automatic t_two();
        frame(9'h0A5, 8, 1'b0, 1'b1);
        frame(9'h05A, 8, 1'b0, 1'b1);
        wait_rc();
        chk(12'(irq), 12'h001);
        chk(head() & 12'h7FF, 12'h528);
        pop();
        chk(head() & 12'h7FF, 12'h2D0);
        pop();
        chk({10'h000, rc, irq}, 12'h000);
    endtask
    task automatic t_overrun();
        frame(9'h011, 8, 1'b0, 1'b1);
        frame(9'h022, 8, 1'b0, 1'b1);
        frame(9'h033, 8, 1'b0, 1'b1);
        frame(9'h044, 8, 1'b0, 1'b1);
        chk(head() & 12'h7FF, 12'h088);
        pop();
        chk(head() & 12'h7FF, 12'h110);
        pop();
        chk(head() & 12'h7FF, 12'h198);
        pop();
        chk(12'(rc), 12'h000);
        frame(9'h055, 8, 1'b0, 1'b1);
        wait_rc();
        chk(head() & 12'h7FF, 12'h2AA);
        pop();
    endtask
    task automatic t_errors();
        logic [1:0] md;
        for (int m = 0; m < 4; m++) begin
            md = 2'(m);
            cfg.parity_mode_upper_bit = md[1];
            cfg.parity_mode_lower_bit = md[0];
            frame(9'h096, 8, 1'b1, md[0]);
            wait_rc();
            chk(head() & 12'h7FF, {1'b0, 8'h96, ~md[0], 1'b0,
                md[1] & ~md[0]});
            pop();
        end
        cfg.parity_mode_upper_bit = 1'b0;
    endtask
    task automatic t_sizes();
        cfg.double_speed_bit = 1'b1;
        cfg.character_size_field = 3'h0;
        frame(9'h1FF, 5, 1'b0, 1'b1);
        wait_rc();
        chk(head() & 12'h7FF, 12'h0F8);
        pop();
        cfg.character_size_field = urx_pkg::CSIZE_9BIT;
        frame(9'h155, 9, 1'b0, 1'b1);
        wait_rc();
        chk(head(), 12'hAA8);
        pop();
        cfg.double_speed_bit = 1'b0;
        cfg.character_size_field = 3'h3;
    endtask
    task automatic t_noise();
        tx.glitch(6);
        chk(12'(rc), 12'h000);
    endtask
    task automatic t_disable();
        frame(9'h033, 8, 1'b0, 1'b1);
        wait_rc();
        cfg.receiver_enable_bit = 1'b0;
        repeat (3) @(negedge clk_i);
        chk({10'h000, rc, claim}, 12'h000);
        cfg.receiver_enable_bit = 1'b1;
        repeat (3) @(negedge clk_i);
        chk({10'h000, rc, claim}, 12'h001);
    endtask
    initial begin
        repeat (8) @(negedge clk_i);
        rst_b_i = 1'b1;
        cfg.receiver_enable_bit = 1'b1;
        cfg.receive_complete_irq_enable = 1'b1;
        cfg.global_irq_enable = 1'b1;
        cfg.character_size_field = 3'h3;
        repeat (2) @(negedge clk_i);
        t_two();
        t_overrun();
        t_errors();
        t_sizes();
        t_noise();
        t_disable();
        test_done();
    end
endmodule
